// ### sdbcd_pkg.sv
// Package for the SDRAM block configuration and hit decode logic
package sdbcd_pkg;
  // Register byte offsets (one aligned word each)
  localparam logic [7:0] SDBCD_CFG0_OFF = 8'h00;
  localparam logic [7:0] SDBCD_MASK0_OFF = 8'h04;
  localparam logic [7:0] SDBCD_CFG1_OFF = 8'h08;
  localparam logic [7:0] SDBCD_MASK1_OFF = 8'h0c;
  localparam logic [7:0] SDBCD_BASE0_OFF = 8'h10;
  localparam logic [7:0] SDBCD_BASE1_OFF = 8'h14;
  localparam logic [7:0] SDBCD_STAT_OFF = 8'h18;
  // Configuration field positions
  localparam int SDBCD_PS_LSB = 4;
  localparam int SDBCD_TRIG_BIT = 3;
  localparam int SDBCD_PM_BIT = 2;
  // Mask register field positions
  localparam int SDBCD_BAM_LSB = 18;
  localparam int SDBCD_AM_LSB = 1;
  localparam int SDBCD_VALID_BIT = 0;
  // Writable bit masks; reserved bits read zero
  localparam logic [31:0] SDBCD_CFG_WMASK = 32'h0000_003c;
  localparam logic [31:0] SDBCD_MASK_WMASK = 32'hfffc_007f;
  localparam logic [31:0] SDBCD_BASE_WMASK = 32'hfffc_0000;
  // Reset values
  localparam logic [31:0] SDBCD_CFG_RST = 32'h0000_0000;
  localparam logic [31:0] SDBCD_MASK_RST = 32'h0000_0000;
  // Port width codes
  localparam logic [1:0] SDBCD_PS_8 = 2'h1;
  localparam logic [1:0] SDBCD_PS_BAD = 2'h0;
  // Access type bit order in the six-bit mask
  localparam int SDBCD_T_UD = 0;
  localparam int SDBCD_T_UC = 1;
  localparam int SDBCD_T_SD = 2;
  localparam int SDBCD_T_SC = 3;
  localparam int SDBCD_T_AM = 4;
  localparam int SDBCD_T_CI = 5;
  // Transfer sizes in bytes (log2)
  localparam logic [1:0] SDBCD_SZ_1 = 2'h0;
  localparam logic [1:0] SDBCD_SZ_2 = 2'h1;
  // Controller command codes
  typedef enum logic [2:0]
  {
    SDBCD_CMD_NOP = 3'b000,
    SDBCD_CMD_ACTV = 3'b001,
    SDBCD_CMD_RW = 3'b010,
    SDBCD_CMD_PRE = 3'b011,
    SDBCD_CMD_PRECHARGE_ALL_CMD = 3'b100
  } sdbcd_cmd_t;
  // One bus access request from the internal masters
  typedef struct packed
  {
    logic valid;
    logic write;
    logic [31:0] addr;
    logic [5:0] acc_type;
    logic [1:0] size_log2;
  } sdbcd_req_t;
  // Command issued toward the SDRAM sequencer
  typedef struct packed
  {
    logic valid;
    logic block;
    sdbcd_cmd_t cmd;
    logic column_strobe;
    logic burst;
  } sdbcd_out_t;
endpackage

// ### sdbcd_top.sv
// SDRAM per-block configuration, precharge trigger and hit decode
// Summary of operation
// R1: port width code sizes accesses, 00 unused
// R2: trigger fires precharge-all on next block write
// R3: trigger self-clears when precharge-all completes
// R4: software keeps trigger write within port width
// R5: page policy clear: burst in-page wider transfers
// R6: page policy clear: precharge closes page after burst
// R7: page policy set: page open, column strobe hits
// R8: base mask one excludes address bit 31-18
// R9: access-type mask zero allows, one blocks hit
// R10: six access types classify each access
// R11: valid bit cleared by reset
// R12: invalid block decodes no access
// R13: software writes zero to reserved bits
// R14: hit needs valid, address match, unmasked type
//
// The placing of the registers and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
module sdbcd_top
  import sdbcd_pkg::*;
#(
  parameter int NUM_BLOCKS = 2,
  parameter int PAGE_LSB = 9
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Access request from bus masters, precharge-all completion from the sequencer
  input wire sdbcd_req_t req_i,
  input wire logic precharge_all_cmd_done_i,
  // Decode result and command
  output sdbcd_out_t cmd_o,
  output logic [NUM_BLOCKS-1:0] hit_o,
  output logic [1:0] port_bytes_log2_o
);

  // Elaboration check: two register sets are mapped
  if (NUM_BLOCKS != 2 || PAGE_LSB < 2 || PAGE_LSB > 17)
  begin : g_bad_param
    $error("sdbcd_top: unsupported parameter values");
  end

  // Register storage per block
  logic [31:0] cfg_q [NUM_BLOCKS];
  logic [31:0] cfg_d [NUM_BLOCKS];
  logic [31:0] mask_q [NUM_BLOCKS];
  logic [31:0] mask_d [NUM_BLOCKS];
  logic [31:0] base_q [NUM_BLOCKS];
  logic [31:0] base_d [NUM_BLOCKS];
  // Open page tracking per block
  logic [NUM_BLOCKS-1:0] open_q;
  logic [NUM_BLOCKS-1:0] open_d;
  logic [31:PAGE_LSB] page_q [NUM_BLOCKS];
  logic [31:PAGE_LSB] page_d [NUM_BLOCKS];
  // Precharge-all in flight flags
  logic [NUM_BLOCKS-1:0] precharge_all_cmd_busy_q;
  logic [NUM_BLOCKS-1:0] precharge_all_cmd_busy_d;
  // Per-block combinational hit
  logic [NUM_BLOCKS-1:0] hit;
  // APB outputs
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic pready_q;
  logic pready_d;
  logic pslverr_q;
  logic pslverr_d;
  // Command outputs
  sdbcd_out_t cmd_q;
  sdbcd_out_t cmd_d;
  logic [NUM_BLOCKS-1:0] hit_q;
  logic [1:0] pbytes_q;
  logic [1:0] pbytes_d;
  // APB access phase strobe
  logic apb_acc;

  assign apb_acc = psel_i && penable_i && !pready_q;

  // Hit decode per block
  for (genvar b = 0; b < NUM_BLOCKS; b++)
  begin : g_hit
    logic addr_ok;
    logic type_ok;
    // R8: masked address compare
    assign addr_ok = &((~(req_i.addr[31:SDBCD_BAM_LSB] ^
                          base_q[b][31:SDBCD_BAM_LSB])) |
                       mask_q[b][31:SDBCD_BAM_LSB]);
    // R9: access type gating
    // R10: one-hot six-type class
    assign type_ok = |(req_i.acc_type &
                       ~mask_q[b][SDBCD_AM_LSB +: 6]);
    // R14: valid, address and type combined
    assign hit[b] = req_i.valid && mask_q[b][SDBCD_VALID_BIT] &&
                    addr_ok && type_ok;
  end

  // Register file and page state next values
  always_comb
  begin
    logic [7:0] off;
    off = paddr_i;
    prdata_d = prdata_q;
    pready_d = 1'b0;
    pslverr_d = 1'b0;
    open_d = open_q;
    precharge_all_cmd_busy_d = precharge_all_cmd_busy_q;
    cmd_d = '0;
    pbytes_d = pbytes_q;
    for (int b = 0; b < NUM_BLOCKS; b++)
    begin
      cfg_d[b] = cfg_q[b];
      mask_d[b] = mask_q[b];
      base_d[b] = base_q[b];
      page_d[b] = page_q[b];
    end
    // APB access phase, one wait cycle
    if (apb_acc)
    begin
      pready_d = 1'b1;
      prdata_d = 32'h0000_0000;
      case (off)
        SDBCD_CFG0_OFF, SDBCD_CFG1_OFF:
        begin
          // Writing zero to the trigger has no effect
          if (pwrite_i)
            cfg_d[off[3]] = (pwdata_i & SDBCD_CFG_WMASK) |
                            (cfg_q[off[3]] &
                             (32'h1 << SDBCD_TRIG_BIT));
          else
            prdata_d = cfg_q[off[3]];
        end
        SDBCD_MASK0_OFF, SDBCD_MASK1_OFF:
        begin
          // R13: reserved bits dropped on write
          if (pwrite_i)
            mask_d[off[3]] = pwdata_i & SDBCD_MASK_WMASK;
          else
            prdata_d = mask_q[off[3]];
        end
        SDBCD_BASE0_OFF, SDBCD_BASE1_OFF:
        begin
          if (pwrite_i)
            base_d[off[2]] = pwdata_i & SDBCD_BASE_WMASK;
          else
            prdata_d = base_q[off[2]];
        end
        SDBCD_STAT_OFF:
        begin
          // Status shows open pages and pending precharge-all
          if (!pwrite_i)
            prdata_d = {28'h0, precharge_all_cmd_busy_q, open_q};
        end
        default:
        begin
          // Unmapped address answers with an error
          pslverr_d = 1'b1;
        end
      endcase
    end
    // Command generation for a hitting access
    for (int b = 0; b < NUM_BLOCKS; b++)
    begin
      // R3: self-clear after precharge-all completes
      if (precharge_all_cmd_busy_q[b] && precharge_all_cmd_done_i)
      begin
        precharge_all_cmd_busy_d[b] = 1'b0;
        // A trigger written in the same cycle wins over the clear
        cfg_d[b][SDBCD_TRIG_BIT] = apb_acc && pwrite_i &&
          pwdata_i[SDBCD_TRIG_BIT] &&
          off == (b[0] ? SDBCD_CFG1_OFF : SDBCD_CFG0_OFF);
        open_d[b] = 1'b0;
      end
      if (hit[b])
      begin
        logic ps8;
        logic same_page;
        logic wide;
        // R1: code 01 is 8-bit, 1x is 16-bit
        ps8 = cfg_q[b][SDBCD_PS_LSB +: 2] == SDBCD_PS_8;
        pbytes_d = ps8 ? SDBCD_SZ_1 : SDBCD_SZ_2;
        wide = req_i.size_log2 > (ps8 ? SDBCD_SZ_1 : SDBCD_SZ_2);
        same_page = open_q[b] && page_q[b] == req_i.addr[31:PAGE_LSB];
        cmd_d.valid = 1'b1;
        cmd_d.block = b[0];
        if (cfg_q[b][SDBCD_PS_LSB +: 2] == SDBCD_PS_BAD)
          cmd_d.valid = 1'b0;
        // R2: pending trigger fires on a block write
        else if (cfg_q[b][SDBCD_TRIG_BIT] && req_i.write &&
                 !precharge_all_cmd_busy_q[b])
        begin
          cmd_d.cmd = SDBCD_CMD_PRECHARGE_ALL_CMD;
          precharge_all_cmd_busy_d[b] = 1'b1;
        end
        // R7: open page hit needs column strobe only
        else if (cfg_q[b][SDBCD_PM_BIT] && same_page)
        begin
          cmd_d.cmd = SDBCD_CMD_RW;
          cmd_d.column_strobe = 1'b1;
          cmd_d.burst = wide;
        end
        else if (cfg_q[b][SDBCD_PM_BIT])
        begin
          // Continuous mode: activate and keep page open
          cmd_d.cmd = SDBCD_CMD_ACTV;
          open_d[b] = 1'b1;
          page_d[b] = req_i.addr[31:PAGE_LSB];
        end
        else
        begin
          // R5: burst only when wider than port
          cmd_d.cmd = SDBCD_CMD_ACTV;
          cmd_d.burst = wide;
          // R6: page closed by precharge after burst
          open_d[b] = 1'b0;
        end
      end
    end
  end

  // R11: registers and valid bit cleared at reset
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (int b = 0; b < NUM_BLOCKS; b++)
      begin
        cfg_q[b] <= SDBCD_CFG_RST;
        mask_q[b] <= SDBCD_MASK_RST;
        base_q[b] <= '0;
        page_q[b] <= '0;
      end
      open_q <= '0;
      precharge_all_cmd_busy_q <= '0;
      prdata_q <= '0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      cmd_q <= '0;
      hit_q <= '0;
      pbytes_q <= '0;
    end
    else
    begin
      for (int b = 0; b < NUM_BLOCKS; b++)
      begin
        cfg_q[b] <= cfg_d[b];
        mask_q[b] <= mask_d[b];
        base_q[b] <= base_d[b];
        page_q[b] <= page_d[b];
      end
      open_q <= open_d;
      precharge_all_cmd_busy_q <= precharge_all_cmd_busy_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      cmd_q <= cmd_d;
      // R12: no decode while invalid
      hit_q <= hit;
      pbytes_q <= pbytes_d;
    end
  end

  // Outputs straight from flip-flops
  assign prdata_o = prdata_q;
  assign pready_o = pready_q;
  assign pslverr_o = pslverr_q;
  assign cmd_o = cmd_q;
  assign hit_o = hit_q;
  assign port_bytes_log2_o = pbytes_q;

endmodule // sdbcd_top

// ### sdbcd_monitor.sv
// Port checker for the SDRAM block decode
`timescale 1ns/1ps
module sdbcd_monitor
  import sdbcd_pkg::*;
#(
  parameter int NUM_BLOCKS = 2
)
(
  // Clock, reset and bus
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // Decode side
  input wire sdbcd_req_t req_i,
  input wire sdbcd_out_t cmd_o,
  input wire logic [NUM_BLOCKS-1:0] hit_o,
  input wire logic [1:0] port_bytes_log2_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_rst_clr;
    $past(rst_i) |-> hit_o == '0 && !cmd_o.valid;
  endproperty
  a_rst_clr: assert property (p_rst_clr)
    else $error("outputs not clear after reset");
  property p_no_req;
    !req_i.valid |=> hit_o == '0;
  endproperty
  a_no_req: assert property (p_no_req)
    else $error("hit without a request");
  property p_cmd_hit;
    cmd_o.valid |-> hit_o[cmd_o.block];
  endproperty
  a_cmd_hit: assert property (p_cmd_hit)
    else $error("command for a block that missed");
  property p_precharge_all_cmd_wr;
    cmd_o.valid && cmd_o.cmd == SDBCD_CMD_PRECHARGE_ALL_CMD |-> $past(req_i.write);
  endproperty
  a_precharge_all_cmd_wr: assert property (p_precharge_all_cmd_wr)
    else $error("precharge-all not from a write");
  property p_burst;
    cmd_o.valid && cmd_o.burst |->
      $past(req_i.size_log2) > port_bytes_log2_o;
  endproperty
  a_burst: assert property (p_burst)
    else $error("burst not wider than port");
  property p_rdy;
    psel_i && penable_i && !pready_o |=> pready_o;
  endproperty
  a_rdy: assert property (p_rdy)
    else $error("bus access not answered");
  property p_pulse;
    pready_o |=> !pready_o;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("ready held too long");
  property p_err;
    pslverr_o |-> pready_o && prdata_o == '0;
  endproperty
  a_err: assert property (p_err)
    else $error("error without ready or zero data");
endmodule // sdbcd_monitor
bind sdbcd_top sdbcd_monitor #(.NUM_BLOCKS(NUM_BLOCKS)) u_mon (.clk_i,
  .rst_i, .psel_i, .penable_i, .prdata_o, .pready_o, .pslverr_o, .req_i,
  .cmd_o, .hit_o, .port_bytes_log2_o);

// ### sdbcd_sdram_model.sv
// Far-side sequencer model that finishes precharge-all
`timescale 1ns/1ps
module sdbcd_sdram_model
  import sdbcd_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Command in, completion out
  input wire sdbcd_out_t cmd_i,
  output logic precharge_all_cmd_done_o
);
  logic [1:0] cnt_q; // Cycles left in a precharge
  always @(posedge clk_i)
  begin
    precharge_all_cmd_done_o <= !rst_i && cnt_q == 2'h1;
    if (rst_i)
      cnt_q <= 2'h0;
    else if (cmd_i.valid && cmd_i.cmd == SDBCD_CMD_PRECHARGE_ALL_CMD)
      cnt_q <= 2'h3;
    else if (cnt_q != 2'h0)
      cnt_q <= cnt_q - 2'h1;
  end
endmodule // sdbcd_sdram_model

// ### sdbcd_tb_top.sv
// Testbench for the SDRAM block decode
`timescale 1ns/1ps
module sdbcd_tb_top;
  import sdbcd_pkg::*;
  localparam logic [31:0] A = 32'h0004_0000; // Block 0 base
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic [31:0] prdata_o, rdat;
  logic pready_o, pslverr_o, precharge_all_cmd_done_i, perr;
  sdbcd_req_t req_i = '0;
  sdbcd_out_t cmd_o;
  logic [1:0] hit_o, port_bytes_log2_o;
  int n_fail = 0;
  int n_tests = 0;
  int cyc = 0;
  always #12.5 clk_i = ~clk_i;
  sdbcd_top u_dut (.clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .req_i,
    .precharge_all_cmd_done_i, .cmd_o, .hit_o, .port_bytes_log2_o);
  sdbcd_sdram_model u_sdram (.clk_i, .rst_i, .cmd_i(cmd_o),
    .precharge_all_cmd_done_o(precharge_all_cmd_done_i));
  task chk(input string nm, input logic [31:0] s, e);
    n_tests++;
    if (s !== e)
    begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", nm, e, s);
    end
  endtask
  task final_report;
    $display("tests %0d fails %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Bus cycle: setup, access, wait for ready
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    @(posedge clk_i);
    while (pready_o !== 1'b1)
      @(posedge clk_i);
    rdat = prdata_o;
    perr = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  // One access request, result seen a cycle later
  task acc(input logic [31:0] a, input int t, input logic [1:0] sz,
    input logic w);
    @(posedge clk_i);
    req_i <= '{1'b1, w, a, 6'h1 << t, sz};
    @(posedge clk_i);
    req_i.valid <= 1'b0;
    @(negedge clk_i);
  endtask
  task t_reset;
    apb(0, SDBCD_MASK0_OFF, 0);
    chk("mask0", rdat, SDBCD_MASK_RST);
    acc(A, 0, SDBCD_SZ_1, 1'b0);
    chk("hit0", hit_o, 2'h0);
    apb(0, 8'h40, 0);
    chk("err", perr, 1'b1);
  endtask
  task t_types;
    apb(1, SDBCD_BASE0_OFF, A);
    for (int i = 0; i < 6; i++)
    begin
      apb(1, SDBCD_MASK0_OFF, 32'h1 | 32'h1 << (i + 1));
      acc(A, i, SDBCD_SZ_1, 1'b0);
      chk("blk", hit_o, 2'h0);
      acc(A, (i + 1) % 6, SDBCD_SZ_1, 1'b0);
      chk("hit", hit_o, 2'h1);
      chk("ps00", cmd_o.valid, 1'b0);
    end
  endtask
  task t_bam;
    acc(32'h0, 0, SDBCD_SZ_1, 1'b0);
    chk("nobam", hit_o, 2'h0);
    apb(1, SDBCD_MASK0_OFF, 32'h0004_0001);
    acc(32'h0, 0, SDBCD_SZ_1, 1'b0);
    chk("bam", hit_o, 2'h1);
  endtask
  task t_width;
    apb(1, SDBCD_CFG0_OFF, 32'h10);
    acc(A, 0, SDBCD_SZ_2, 1'b0);
    chk("ps8", port_bytes_log2_o, 2'h0);
    chk("bst", cmd_o.burst, 1'b1);
    chk("act", cmd_o.cmd, SDBCD_CMD_ACTV);
    chk("blk0", cmd_o.block, 1'b0);
    acc(A, 0, SDBCD_SZ_1, 1'b0);
    chk("nb8", cmd_o.burst, 1'b0);
    apb(1, SDBCD_CFG0_OFF, 32'h20);
    acc(A, 0, SDBCD_SZ_2, 1'b0);
    chk("ps16", port_bytes_log2_o, 2'h1);
    chk("nb16", cmd_o.burst, 1'b0);
  endtask
  task t_page;
    apb(1, SDBCD_CFG0_OFF, 32'h24);
    acc(A, 0, SDBCD_SZ_1, 1'b0);
    acc(A + 32'h4, 0, SDBCD_SZ_1, 1'b0);
    chk("cas", cmd_o.column_strobe, 1'b1);
    chk("rw", cmd_o.cmd, SDBCD_CMD_RW);
  endtask
  task t_precharge_all_cmd;
    apb(1, SDBCD_CFG0_OFF, 32'h2c);
    apb(1, SDBCD_CFG0_OFF, 32'h24);
    apb(0, SDBCD_CFG0_OFF, 0);
    chk("trg", rdat, 32'h2c);
    acc(A, 0, SDBCD_SZ_1, 1'b0);
    chk("rdp", cmd_o.cmd == SDBCD_CMD_PRECHARGE_ALL_CMD, 1'b0);
    // trigger write no wider than port
    acc(A, 0, SDBCD_SZ_1, 1'b1);
    chk("precharge_all_cmd", cmd_o.cmd, SDBCD_CMD_PRECHARGE_ALL_CMD);
    repeat (6) @(posedge clk_i);
    apb(0, SDBCD_CFG0_OFF, 0);
    chk("clr", rdat, 32'h24);
  endtask
  // Cut a hang short
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc > 5000)
    begin
      n_fail++;
      final_report();
    end
  end
  initial
  begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_types();
    t_bam();
    t_width();
    t_page();
    t_precharge_all_cmd();
    final_report();
  end
endmodule // sdbcd_tb_top
